// ===== design/fdc_command_parameters.sv
// Overview of operation
// RQ1: soft reset restores fifo and precomp settings only while lock is clear
// RQ2: density bit one selects double density, zero selects single density
// RQ3: multi-track runs a cylinder from head 0 first sector to head 1 last
// RQ4: after head 0 last sector, multi-track continues at head 1 first sector
// RQ5: sector length is 128 bytes shifted left by size code, codes up to 7
// RQ6: size code zero means 128-byte sector, data length limit sets bytes moved
// RQ7: host must not pick size combinations the drive cannot hold
// RQ8: no-dma flag one interrupts the host for every byte
// RQ9: no-dma flag zero moves bytes by dma request and low acknowledge
// RQ10: perpendicular drive bits change only while overwrite permit is one
// RQ11: polling disable bit set stops drive polling, clear runs it
// RQ12: precompensation start track takes any value 00 to ff
// RQ13: multi-sector transfer starts at the programmed first sector
// RQ14: format initialises sectors-per-track sectors
// RQ15: verify with count enable checks sectors-per-track sectors
// RQ16: skip flag on normal read passes over deleted-mark sectors
// RQ17: skip flag on deleted read accesses only deleted-mark sectors
// RQ18: skip flag clear handles every sector without skipping
// RQ19: step pulses spaced by 0.5 ms units, 0.5 to 8 ms
// RQ20: four status registers loaded at end, read back by host
// RQ21: write gate timing raises write enable early for pre-erase
// RQ22: present cylinder reports head position after the command
// RQ23: fifo enable low bit zero enables fifo, one (default) disables
// RQ24: bytes beyond data length limit withheld on read, zero on write
`timescale 1ns/1ps
`include "fdc_consts.svh"
module fdc_command_parameters #(
    parameter int STEP_UNIT_CYC = `STEP_UNIT_US * `CLK_MHZ,
    parameter int PRE_CYC       = 16,
    parameter int POLL_CYC      = 2048
) (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic [4:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    input  wire logic       dma_ack_n,
    input  wire logic       deleted_mark,
    input  wire logic [7:0] disk_rd_data,
    output logic            dma_request,
    output logic            host_irq,
    output logic            step_pulse,
    output logic            step_dir,
    output logic            write_enable,
    output logic            disk_wr_strobe,
    output logic      [7:0] disk_wr_data,
    output logic            precomp_on,
    output logic            mfm_mode,
    output logic            head_sel,
    output logic            drive_sel,
    output logic      [3:0] perp_drive,
    output logic            fifo_enable_n,
    output logic      [3:0] fifo_threshold,
    output logic            poll_strobe
);
    // parameters the counters cannot serve are refused
    if (STEP_UNIT_CYC < 8 || STEP_UNIT_CYC > 1000000 || PRE_CYC < 1 || PRE_CYC > 65535
        || POLL_CYC < 2 || POLL_CYC > 65535) begin : g_chk
        $error("fdc_command_parameters: timing parameter out of range");
    end

    // reset value of the whole state
    function automatic fdc_pkg::state_t rst_val();
        fdc_pkg::state_t r;
        r        = '0;
        r.conf   = `CONF_RST;
        r.precomp_start_track = `PRECOMP_START_TRACK_RST;
        r.ack_m  = 1'b1;
        r.ack_s  = 1'b1;
        return r;
    endfunction
    localparam fdc_pkg::state_t ST_RST = rst_val();

    fdc_pkg::state_t q;
    fdc_pkg::state_t d;
    logic [14:0]     seclen;
    logic [14:0]     limit;
    logic            rdop;
    logic            wrop;
    logic            xfer;
    logic            cmode;
    logic            last;
    logic            dacc;
    logic [7:0]      rmux;

    // sector length and host byte limit
    always_comb begin
        seclen = `SEC_BASE << q.n; // RQ5
        limit  = (q.n == 3'h0) ? {7'h00, q.data_length_limit} : seclen; // RQ6
        rdop   = (q.op == fdc_pkg::OP_READ) || (q.op == fdc_pkg::OP_RDDEL);
        wrop   = (q.op == fdc_pkg::OP_WRITE) || (q.op == fdc_pkg::OP_FORMAT);
        cmode  = (q.op == fdc_pkg::OP_FORMAT) || // RQ14
                 ((q.op == fdc_pkg::OP_VERIFY) && q.mode[`M_EC]); // RQ15
        last   = cmode ? (q.scnt + 8'h01 == q.spt) : (q.cur == q.eot);
        xfer   = !q.skip && (rdop || q.op == fdc_pkg::OP_WRITE) && (q.bcnt < limit); // RQ24
        dacc   = (rd || wr) && (addr == `A_DATA);
    end

    // register read mux
    always_comb begin
        case (addr)
            `A_MODE:   rmux = q.mode;
            `A_SIZE:   rmux = {5'h00, q.n};
            `A_DTL:    rmux = q.data_length_limit;
            `A_SPT:    rmux = q.spt;
            `A_FIRST:  rmux = q.first;
            `A_EOT:    rmux = q.eot;
            `A_STEP:   rmux = {4'h0, q.step_rate_interval};
            `A_CYL:    rmux = q.tcyl;
            `A_CONF:   rmux = q.conf;
            `A_PRECOMP_START_TRACK: rmux = q.precomp_start_track;
            `A_PERP:   rmux = {4'h0, q.perp};
            `A_LOCK:   rmux = {6'h00, q.ow, q.lock};
            `A_CTL:    rmux = {q.busy, 4'h0, q.op};
            `A_DATA:   rmux = q.data;
            `A_ST0:    rmux = q.st0; // RQ20
            `A_ST1:    rmux = q.st1;
            `A_ST2:    rmux = q.st2;
            `A_ST3:    rmux = q.st3;
            `A_PCN:    rmux = q.present_cylinder; // RQ22
            default:   rmux = 8'h00;
        endcase
    end

    // next state
    always_comb begin
        d       = q;
        d.ack_m = dma_ack_n;
        d.ack_s = q.ack_m;
        d.del_m = deleted_mark;
        d.del_s = q.del_m;
        d.rdd_m = disk_rd_data;
        d.rdd_s = q.rdd_m;
        d.step  = 1'b0;
        d.wstb  = 1'b0;
        d.poll  = 1'b0;
        d.rdata = rd ? rmux : 8'h00;
        d.pcmp  = wrop && q.we && (q.present_cylinder >= q.precomp_start_track); // RQ12
        // register writes
        if (wr) begin
            case (addr)
                `A_MODE:   d.mode = wdata; // RQ2
                `A_SIZE:   d.n = wdata[2:0];
                `A_DTL:    d.data_length_limit = wdata;
                `A_SPT:    d.spt = wdata;
                `A_FIRST:  d.first = wdata;
                `A_EOT:    d.eot = wdata;
                `A_STEP:   d.step_rate_interval = wdata[3:0];
                `A_CYL:    d.tcyl = wdata;
                `A_CONF:   d.conf = wdata; // RQ23
                `A_PRECOMP_START_TRACK: d.precomp_start_track = wdata; // RQ12
                `A_PERP:   if (q.ow) d.perp = wdata[3:0]; // RQ10
                `A_LOCK: begin
                    d.lock = wdata[0];
                    d.ow   = wdata[1];
                end
                default: ;
            endcase
        end
        // command engine
        case (q.ph)
            fdc_pkg::P_IDLE: begin
                if (wr && addr == `A_CTL && !wdata[`CTL_RST] && wdata[2:0] <= 3'h5) begin
                    d.op   = fdc_pkg::op_t'(wdata[2:0]);
                    d.busy = 1'b1;
                    d.cur  = q.first; // RQ13
                    d.head = q.mode[`M_HEAD]; // RQ3
                    d.scnt = 8'h00;
                    d.st2  = 8'h00;
                    d.cnt  = 24'h0;
                    if (wdata[2:0] == 3'h5) begin
                        d.ph = fdc_pkg::P_STEP;
                    end else if (wdata[2:0] == 3'h2 && q.mode[`M_WG]
                                 && q.perp[q.mode[`M_DRV]]) begin
                        d.ph  = fdc_pkg::P_PRE; // RQ21
                        d.we  = 1'b1;
                        d.cnt = 24'(PRE_CYC);
                    end else begin
                        d.ph = fdc_pkg::P_SECT;
                    end
                end
            end
            fdc_pkg::P_STEP: begin
                if (q.cnt != 24'h0) begin
                    d.cnt = q.cnt - 24'h1;
                end else if (q.present_cylinder == q.tcyl) begin
                    d.ph = fdc_pkg::P_DONE;
                end else begin
                    d.step = 1'b1; // RQ19
                    d.dir  = q.tcyl > q.present_cylinder;
                    d.present_cylinder  = (q.tcyl > q.present_cylinder) ? q.present_cylinder + 8'h01 : q.present_cylinder - 8'h01;
                    d.cnt  = 24'(({20'h0, q.step_rate_interval} + 24'h1) * 24'(STEP_UNIT_CYC)); // RQ19
                end
            end
            fdc_pkg::P_PRE: begin
                if (q.cnt > 24'h1) d.cnt = q.cnt - 24'h1;
                else d.ph = fdc_pkg::P_SECT;
            end
            fdc_pkg::P_SECT: begin
                d.skip = q.mode[`M_SK] && ( // RQ18
                         (q.op == fdc_pkg::OP_READ && q.del_s) || // RQ16
                         (q.op == fdc_pkg::OP_RDDEL && !q.del_s)); // RQ17
                d.st2[6] = q.st2[6] | (q.del_s ^ (q.op == fdc_pkg::OP_RDDEL));
                d.bcnt = 15'h0;
                if (wrop) d.we = 1'b1;
                d.ph = fdc_pkg::P_BYTE;
            end
            fdc_pkg::P_BYTE: begin
                if (q.bcnt == seclen) begin
                    d.scnt = q.scnt + 8'h01;
                    if (!last) begin
                        d.cur = q.cur + 8'h01;
                        d.ph  = fdc_pkg::P_SECT;
                    end else if (q.mode[`M_MT] && !q.head && !cmode) begin
                        d.head = 1'b1; // RQ4
                        d.cur  = 8'h01;
                        d.ph   = fdc_pkg::P_SECT;
                    end else begin
                        d.ph = fdc_pkg::P_DONE;
                    end
                end else if (xfer) begin
                    if (rdop) d.data = q.rdd_s;
                    d.dreq = !q.mode[`M_ND]; // RQ9
                    d.irq  = q.mode[`M_ND]; // RQ8
                    d.ph   = fdc_pkg::P_HOST;
                end else begin
                    if (wrop) begin
                        d.wstb = 1'b1; // RQ24
                        d.wdat = 8'h00;
                    end
                    d.bcnt = q.bcnt + 15'h1;
                end
            end
            fdc_pkg::P_HOST: begin
                if (dacc && (q.mode[`M_ND] || !q.ack_s)) begin // RQ9
                    d.dreq = 1'b0;
                    d.irq  = 1'b0;
                    if (wrop) begin
                        d.wstb = 1'b1;
                        d.wdat = wdata;
                    end
                    d.bcnt = q.bcnt + 15'h1;
                    d.ph   = fdc_pkg::P_BYTE;
                end
            end
            fdc_pkg::P_DONE: begin
                d.we   = 1'b0;
                d.busy = 1'b0;
                d.ph   = fdc_pkg::P_IDLE;
                d.st0  = {2'b00, q.op == fdc_pkg::OP_SEEK, 2'b00, q.head, 1'b0, q.mode[`M_DRV]};
                d.st1  = {rdop && q.cur == q.eot && !q.mode[`M_MT], 7'h00};
                d.st3  = {3'b001, q.present_cylinder == 8'h00, 1'b0, q.head, 1'b0, q.mode[`M_DRV]};
            end
            default: d.ph = fdc_pkg::P_IDLE;
        endcase
        // drive polling while idle
        if (q.ph == fdc_pkg::P_IDLE && !q.conf[`C_POLL]) begin // RQ11
            if (q.pcnt >= 16'(POLL_CYC - 1)) begin
                d.pcnt = 16'h0;
                d.poll = 1'b1;
            end else begin
                d.pcnt = q.pcnt + 16'h1;
            end
        end else begin
            d.pcnt = 16'h0;
        end
        // soft reset aborts the command; lock protects configuration
        if (wr && addr == `A_CTL && wdata[`CTL_RST]) begin
            d.ph   = fdc_pkg::P_IDLE;
            d.busy = 1'b0;
            d.dreq = 1'b0;
            d.irq  = 1'b0;
            d.we   = 1'b0;
            if (!q.lock) begin // RQ1
                d.conf   = `CONF_RST; // RQ23
                d.precomp_start_track = `PRECOMP_START_TRACK_RST;
            end
        end
    end

    // state register
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) q <= ST_RST;
        else q <= d;
    end

    // outputs straight from the state register
    assign rdata          = q.rdata;
    assign dma_request    = q.dreq;
    assign host_irq       = q.irq;
    assign step_pulse     = q.step;
    assign step_dir       = q.dir;
    assign write_enable   = q.we;
    assign disk_wr_strobe = q.wstb;
    assign disk_wr_data   = q.wdat;
    assign precomp_on     = q.pcmp;
    assign mfm_mode       = q.mode[`M_MFM];
    assign head_sel       = q.head;
    assign drive_sel      = q.mode[`M_DRV];
    assign perp_drive     = q.perp;
    assign fifo_enable_n  = q.conf[`C_FIFON];
    assign fifo_threshold = q.conf[3:0];
    assign poll_strobe    = q.poll;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    sequence soft_rst_s;
        wr && addr == `A_CTL && wdata[`CTL_RST];
    endsequence
    sequence dma_take_s;
        q.ph == fdc_pkg::P_HOST && !q.mode[`M_ND] && !q.ack_s && dacc;
    endsequence

    density_sel_a: assert property (wr && addr == `A_MODE |=> mfm_mode == $past(wdata[0])) // RQ2
        else $error("density select not taken");
    lock_keep_a: assert property (soft_rst_s ##0 q.lock // RQ1
        |=> $stable(q.conf) && $stable(q.precomp_start_track))
        else $error("locked config lost on soft reset");
    unlock_dflt_a: assert property (soft_rst_s ##0 !q.lock // RQ1
        |=> fifo_enable_n && q.precomp_start_track == 8'h00)
        else $error("config not defaulted on soft reset");
    perp_guard_a: assert property (!q.ow && !(wr && addr == `A_LOCK) // RQ10
        |=> $stable(perp_drive))
        else $error("perpendicular bits changed without permit");
    poll_off_a: assert property ($past(q.conf[`C_POLL]) && q.conf[`C_POLL] // RQ11
        |-> !poll_strobe)
        else $error("polling while disabled");
    mode_hs_a: assert property ((dma_request |-> !q.mode[`M_ND]) // RQ8
        and (host_irq |-> q.mode[`M_ND]))
        else $error("wrong transfer handshake for mode");
    dma_done_a: assert property (dma_take_s |=> !dma_request && q.ph == fdc_pkg::P_BYTE) // RQ9
        else $error("dma handshake not completed");
    step_gap_a: assert property (step_pulse |=> !step_pulse[*8]) // RQ19
        else $error("step pulses too close");
    limit_hold_a: assert property (q.ph == fdc_pkg::P_HOST |-> q.bcnt < limit) // RQ24
        else $error("byte beyond limit passed to host");
    first_sec_a: assert property (q.ph == fdc_pkg::P_IDLE && wr && addr == `A_CTL // RQ13
        && !wdata[`CTL_RST] && wdata[2:0] <= 3'h5 |=> q.cur == $past(q.first))
        else $error("transfer not started at first sector");
    head_next_a: assert property (q.ph == fdc_pkg::P_BYTE && q.bcnt == seclen && last // RQ4
        && q.mode[`M_MT] && !q.head && !cmode |=> head_sel && q.cur == 8'h01)
        else $error("multi-track head switch missing");
    done_res_a: assert property (q.ph == fdc_pkg::P_DONE // RQ20
        |=> !q.busy && q.st3[4] == $past(q.present_cylinder == 8'h00))
        else $error("status not loaded at end");
endmodule // fdc_command_parameters

// ===== inc/fdc_consts.svh
`ifndef FDC_CONSTS_SVH
`define FDC_CONSTS_SVH
// register offsets
`define A_MODE     5'h00
`define A_SIZE     5'h01
`define A_DTL      5'h02
`define A_SPT      5'h03
`define A_FIRST    5'h04
`define A_EOT      5'h05
`define A_STEP     5'h06
`define A_CYL      5'h07
`define A_CONF     5'h08
`define A_PRECOMP_START_TRACK   5'h09
`define A_PERP     5'h0a
`define A_LOCK     5'h0b
`define A_CTL      5'h0c
`define A_DATA     5'h0d
`define A_ST0      5'h10
`define A_ST1      5'h11
`define A_ST2      5'h12
`define A_ST3      5'h13
`define A_PCN      5'h14
// mode register fields
`define M_MFM      0
`define M_MT       1
`define M_SK       2
`define M_ND       3
`define M_EC       4
`define M_WG       5
`define M_DRV      6
`define M_HEAD     7
// configure register fields and reset values
`define C_POLL     4
`define C_FIFON    5
`define CONF_RST   8'h20
`define PRECOMP_START_TRACK_RST 8'h00
// control register fields
`define CTL_RST    7
`define CTL_BUSY   7
// timing
`define CLK_MHZ    50
`define STEP_UNIT_US 500
`define SEC_BASE   15'h0080
`endif

// ===== inc/fdc_pkg.sv
package fdc_pkg;
    typedef enum logic [2:0] {
        P_IDLE = 3'b000,
        P_STEP = 3'b001,
        P_PRE  = 3'b010,
        P_SECT = 3'b011,
        P_BYTE = 3'b100,
        P_HOST = 3'b101,
        P_DONE = 3'b110
    } phase_t;
    typedef enum logic [2:0] {
        OP_READ   = 3'b000,
        OP_RDDEL  = 3'b001,
        OP_WRITE  = 3'b010,
        OP_FORMAT = 3'b011,
        OP_VERIFY = 3'b100,
        OP_SEEK   = 3'b101
    } op_t;
    typedef struct packed {
        phase_t      ph;
        op_t         op;
        logic [7:0]  mode;
        logic [2:0]  n;
        logic [7:0]  data_length_limit;
        logic [7:0]  spt;
        logic [7:0]  first;
        logic [7:0]  eot;
        logic [3:0]  step_rate_interval;
        logic [7:0]  tcyl;
        logic [7:0]  present_cylinder;
        logic [7:0]  conf;
        logic [7:0]  precomp_start_track;
        logic [3:0]  perp;
        logic        lock;
        logic        ow;
        logic [7:0]  st0;
        logic [7:0]  st1;
        logic [7:0]  st2;
        logic [7:0]  st3;
        logic [7:0]  cur;
        logic        head;
        logic [14:0] bcnt;
        logic [7:0]  scnt;
        logic        skip;
        logic [23:0] cnt;
        logic [7:0]  data;
        logic [7:0]  rdata;
        logic        dreq;
        logic        irq;
        logic        step;
        logic        dir;
        logic        we;
        logic        wstb;
        logic [7:0]  wdat;
        logic        pcmp;
        logic        poll;
        logic [15:0] pcnt;
        logic        busy;
        logic        ack_m;
        logic        ack_s;
        logic        del_m;
        logic        del_s;
        logic [7:0]  rdd_m;
        logic [7:0]  rdd_s;
    } state_t;
endpackage

// ===== verif/fdc_far_side.sv
`timescale 1ns/1ps
// dma controller and drive as seen from the block's far side
module fdc_far_side (
    input  wire logic       mclk,
    input  wire logic       nrst,
    input  wire logic       dma_request,
    input  wire logic [3:0] ack_delay,
    input  wire logic       mark_in,
    input  wire logic [7:0] byte_in,
    output logic            dma_ack_n,
    output logic            deleted_mark,
    output logic      [7:0] disk_rd_data
);
    int wait_q;

    // acknowledge a request after a chosen delay, release once it drops
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dma_ack_n <= 1'b1;
            wait_q    <= 0;
        end else if (!dma_request) begin
            dma_ack_n <= 1'b1;
            wait_q    <= 0;
        end else if (wait_q >= ack_delay) begin
            dma_ack_n <= 1'b0;
        end else begin
            wait_q <= wait_q + 1;
        end
    end

    // drive levels: sector mark and read byte held through a command
    assign deleted_mark = mark_in;
    assign disk_rd_data = byte_in;
endmodule // fdc_far_side

// ===== verif/fdc_command_parameters_bench.sv
`timescale 1ns/1ps
`include "fdc_consts.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end
module fdc_command_parameters_bench;
    logic        mclk, nrst, wr, rd, mark_in, dma_ack_n, deleted_mark;
    logic [4:0]  addr;
    logic [7:0]  wdata, rdata, disk_rd_data, disk_byte, disk_wr_data, v, md, dl;
    logic [3:0]  ack_delay, perp_drive, fifo_threshold, mk, op, n, eo;
    logic        dma_request, host_irq, step_pulse, step_dir, write_enable, disk_wr_strobe;
    logic        precomp_on, mfm_mode, head_sel, drive_sel, fifo_enable_n, poll_strobe;
    int          err_count, tests_run, cyc, last_step, polls, nb, lead, lead0, c0;
    bit          head_seen, pre_seen;
    logic [8:0]  wq[$];
    int          sq[$];
    logic [31:0] seed_q;
    // {mode, mark, op, size code, limit, end sector}; sizes the drive holds
    logic [31:0] rt [7] = '{32'h0100_0042, 32'h0900_3ff1, 32'h0510_0041, 32'h0110_0041,
                            32'h0511_0041, 32'h0401_0041, 32'h0300_0042};

    fdc_command_parameters #(.STEP_UNIT_CYC(8), .POLL_CYC(8)) u_dut (
        .mclk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .dma_ack_n, .deleted_mark,
        .disk_rd_data, .dma_request, .host_irq, .step_pulse, .step_dir, .write_enable,
        .disk_wr_strobe, .disk_wr_data, .precomp_on, .mfm_mode, .head_sel, .drive_sel,
        .perp_drive, .fifo_enable_n, .fifo_threshold, .poll_strobe);
    fdc_far_side u_far (.mclk, .nrst, .dma_request, .ack_delay, .mark_in,
        .byte_in(disk_byte), .dma_ack_n, .deleted_mark, .disk_rd_data);

    // 50 MHz clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // watchdog: the whole run needs well under 100k cycles
    initial begin
        #2_000_000;
        err_count++;
        give_verdict();
    end

    // disk side monitor: written bytes, step spacing, head and precomp seen
    always @(posedge mclk) begin
        cyc++;
        if (disk_wr_strobe) wq.push_back({write_enable, disk_wr_data});
        if (step_pulse) begin
            sq.push_back((cyc - last_step) * 2 + step_dir);
            last_step = cyc;
        end
        if (head_sel) head_seen = 1;
        if (precomp_on) pre_seen = 1;
        if (poll_strobe) polls++;
        if (write_enable && wq.size() == 0) lead++;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // reference: bytes offered to the host by one read command
    function automatic int model_bytes(logic [7:0] m, logic [3:0] o, logic k,
                                       logic [3:0] c, logic [7:0] l, logic [3:0] e);
        int sz;
        sz = 128 << c;
        if (c == 0 && l < 128) sz = l;
        if (m[2] && (o == 0 ? k : !k)) return 0;
        return sz * e * (m[1] ? 2 : 1);
    endfunction

    task automatic wreg(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    task automatic rreg(input logic [4:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic clr();
        wq.delete();
        sq.delete();
        head_seen = 0;
        pre_seen = 0;
        lead = 0;
    endtask

    // start a command and serve every byte it offers until busy drops
    task automatic run_op(input logic [2:0] o, input bit wop, input bit nod);
        int g;
        logic [7:0] b;
        g = 0;
        nb = 0;
        b = 8'h80;
        wreg(`A_CTL, {5'h00, o});
        while (b[7] && g < 30000) begin
            g++;
            if (dma_request || host_irq) begin
                `CHK({dma_request, host_irq}, nod ? 2'b01 : 2'b10)
                while (!nod && dma_ack_n && g < 30000) begin
                    @(posedge mclk);
                    g++;
                end
                repeat (3) @(posedge mclk);
                if (wop) wreg(`A_DATA, 8'ha5);
                else begin
                    rreg(`A_DATA, b);
                    `CHK(b, disk_byte)
                end
                nb++;
                b = 8'h80;
                repeat (2) @(posedge mclk);
            end else rreg(`A_CTL, b);
        end
        if (g >= 30000) err_count++;
    endtask

    task automatic give_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // main sequence
    initial begin
        nrst = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 5'h00;
        wdata = 8'h00;
        mark_in = 1'b0;
        ack_delay = 4'h0;
        disk_byte = 8'h00;
        seed_q = 32'hfdedc2f7;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        repeat (2) @(posedge mclk);
        rreg(`A_CONF, v);
        `CHK({v, fifo_enable_n, dma_request, write_enable}, 11'h104)
        // lock clear: soft reset restores defaults; lock set: settings survive
        for (int k = 0; k < 2; k++) begin
            seed_q = lfsr(seed_q);
            wreg(`A_LOCK, {7'h00, k[0]});
            wreg(`A_CONF, 8'h0a);
            wreg(`A_PRECOMP_START_TRACK, seed_q[7:0]);
            rreg(`A_PRECOMP_START_TRACK, v);
            `CHK(v, seed_q[7:0])
            `CHK({fifo_enable_n, fifo_threshold}, 5'h0a)
            polls = 0;
            repeat (40) @(posedge mclk);
            `CHK(polls inside {[4:6]}, 1'b1)
            wreg(`A_CTL, 8'h80);
            rreg(`A_CONF, v);
            `CHK(v, k ? 8'h0a : 8'h20)
            rreg(`A_PRECOMP_START_TRACK, v);
            `CHK(v, k ? seed_q[7:0] : 8'h00)
        end
        wreg(`A_CONF, 8'h1a);
        polls = 0;
        repeat (40) @(posedge mclk);
        `CHK(polls, 0)
        // perpendicular bits locked until overwrite is permitted; unmapped reads zero
        wreg(`A_PERP, 8'h05);
        rreg(5'h1f, v);
        `CHK({v, perp_drive}, 12'h000)
        wreg(`A_LOCK, 8'h02);
        wreg(`A_PERP, 8'h05);
        rreg(`A_PERP, v);
        `CHK({v, perp_drive}, 12'h055)
        // seeks: step count, direction and spacing, then position and status
        for (int k = 0; k < 2; k++) begin
            clr();
            wreg(`A_STEP, k ? 8'h0f : 8'h00);
            wreg(`A_CYL, k ? 8'h01 : 8'h03);
            run_op(3'd5, 0, 0);
            `CHK(sq.size(), k ? 2 : 3)
            for (int j = 0; j < sq.size(); j++) begin
                `CHK(sq[j] % 2, 1 - k)
                if (j > 0) `CHK((sq[j] / 2) inside {[(k*120+8):(k*120+10)]}, 1'b1)
            end
            rreg(`A_PCN, v);
            `CHK(v, k ? 8'h01 : 8'h03)
            rreg(`A_ST0, v);
            `CHK(v[5], 1'b1)
        end
        // reads from the table, dma prompt and slow, with and without skipping
        for (int k = 0; k < 7; k++) begin
            {md, mk, op, n, dl, eo} = rt[k];
            seed_q = lfsr(seed_q);
            disk_byte <= seed_q[7:0];
            mark_in <= mk[0];
            ack_delay <= k[0] ? 4'h5 : 4'h0;
            wreg(`A_MODE, md);
            wreg(`A_SIZE, {4'h0, n});
            wreg(`A_DTL, dl);
            wreg(`A_FIRST, 8'h01);
            wreg(`A_EOT, {4'h0, eo});
            clr();
            run_op(op[2:0], 0, md[3]);
            `CHK(nb, model_bytes(md, op, mk[0], n, dl, eo))
            `CHK(head_seen, md[1])
            `CHK({drive_sel, mfm_mode}, {md[6], md[0]})
        end
        // writes: bytes past the limit are zero, precomp against the start track
        for (int k = 0; k < 2; k++) begin
            wreg(`A_PRECOMP_START_TRACK, k ? 8'hff : 8'h01);
            wreg(`A_MODE, k ? 8'h21 : 8'h01);
            wreg(`A_SIZE, 8'h00);
            wreg(`A_DTL, 8'h02);
            wreg(`A_EOT, 8'h01);
            clr();
            run_op(3'd2, 1, 0);
            `CHK(nb, 2)
            `CHK(wq.size(), 128)
            foreach (wq[j]) `CHK(wq[j], j < 2 ? 9'h1a5 : 9'h100)
            `CHK(pre_seen, !k)
            // pre-erase lead: write enable rises sixteen cycles early, one more at start
            if (k) `CHK(lead inside {[lead0 + 16:lead0 + 18]}, 1'b1)
            lead0 = lead;
        end
        // format lays down sectors_per_track zero-filled sectors
        wreg(`A_SPT, 8'h02);
        wreg(`A_SIZE, 8'h01);
        clr();
        run_op(3'd3, 1, 0);
        `CHK(nb, 0)
        `CHK(wq.size(), 512)
        foreach (wq[j]) `CHK(wq[j], 9'h100)
        // verify with count enable walks two 256-byte sectors, nothing to the host
        wreg(`A_MODE, 8'h11);
        c0 = cyc;
        run_op(3'd4, 0, 0);
        `CHK((cyc - c0) inside {[512:540]}, 1'b1)
        `CHK(nb, 0)
        give_verdict();
    end
endmodule // fdc_command_parameters_bench
